// ---- wake_timer_pkg.sv ----
// Package: states, time constants and carrier structs for the wake timer.
// Assumes a 50 MHz core clock; durations are counted in time base ticks.
package wake_timer_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  // One time base tick per millisecond
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

  // Durations in ms as printed
  localparam int unsigned AWAKE_FLOOR_MS = 8;
  localparam int unsigned SLEEP_FLOOR_MS = 128;
  localparam int unsigned GRACE_MS = 1000;
  localparam int unsigned DEBOUNCE_MS = 32;
  localparam int unsigned HOLD_MIN_MS = 128;
  localparam int unsigned HOLD_MAX_MS = 16400;

  localparam int CNT_W = 32;

  typedef enum logic [2:0] {
    ST_AWAKE = 3'b000,
    ST_SLEEP = 3'b001,
    ST_SHUT_OFF = 3'b010,
    ST_OFF = 3'b011,
    ST_FROM_OFF = 3'b100
  } state_t;

  typedef struct packed {
    logic button_input;
    logic sleep_req;
    logic period_done;
    logic ceiling_done;
    logic ceiling_open;
  } ctrl_in_t;

  typedef struct packed {
    logic power_en;
    logic button_clean_out;
    logic wake_from_off_flag;
    logic going_down_flag;
  } ctrl_out_t;

endpackage

// ---- wake_debounce.sv ----
// Debounce filter for the active low pushbutton line.
// Assumes the input is synchronous to clk_i and a 1 ms tick strobe.
`timescale 1ns/1ps
module wake_debounce
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Tick and raw level
  input wire logic tick_i,
  input wire logic raw_i,
  // Filtered level, high when released
  output logic clean_o
);

  logic clean_q, clean_d;
  logic [7:0] cnt_q, cnt_d;

  localparam logic [7:0] DB_TICKS =
    8'(wake_timer_pkg::DEBOUNCE_MS);

  always_comb
  begin
    clean_d = clean_q;
    cnt_d = cnt_q;
    if (raw_i == clean_q)
      cnt_d = 8'h00;
    else if (tick_i)
    begin
      if (cnt_q == DB_TICKS - 8'h01)
      begin
        clean_d = raw_i;
        cnt_d = 8'h00;
      end
      else
        cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clean_q <= 1'b1;
      cnt_q <= 8'h00;
    end
    else
    begin
      clean_q <= clean_d;
      cnt_q <= cnt_d;
    end
  end

  assign clean_o = clean_q;

endmodule // wake_debounce

// ---- wake_timer_power_control.sv ----
// Power control state machine of a periodic wake-up timer.
// Assumes synchronous inputs and an external period/ceiling timer.
`timescale 1ns/1ps
module wake_timer_power_control
#(
  parameter bit INVERTED = 1'b0,
  parameter int unsigned HOLD_MS = wake_timer_pkg::HOLD_MIN_MS,
  parameter int unsigned TICK_CYCLES = wake_timer_pkg::TICK_CYC,
  parameter bit START_RUN = 1'b1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Inputs from the system and external timers
  input wire logic button_input_i,
  input wire logic sleep_req_i,
  input wire logic period_done_i,
  input wire logic ceiling_done_i,
  input wire logic ceiling_open_i,
  // Power enable
  output logic power_en_o,
  // Open drain flags, output enable low means pulling low
  output logic button_clean_out_o,
  output logic button_clean_oe_n_o,
  output logic wake_from_off_flag_o,
  output logic wake_from_off_oe_n_o,
  output logic going_down_flag_o,
  output logic going_down_oe_n_o,
  // Status
  output wake_timer_pkg::state_t state_o
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and time base
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  wake_timer_pkg::ctrl_in_t in_s;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam logic [31:0] AWAKE_T = 32'(wake_timer_pkg::AWAKE_FLOOR_MS);
  localparam logic [31:0] SLEEP_T = 32'(wake_timer_pkg::SLEEP_FLOOR_MS);
  localparam logic [31:0] GRACE_T = 32'(wake_timer_pkg::GRACE_MS);
  localparam logic [31:0] HOLD_T = 32'(HOLD_MS);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  always_comb
  begin
    tick_cnt_d = (tick_cnt_q == TICK_LAST) ? 32'h0 : tick_cnt_q + 32'h1;
  end
  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  assign in_s = '{button_input: button_input_i, sleep_req: sleep_req_i,
                  period_done: period_done_i, ceiling_done: ceiling_done_i,
                  ceiling_open: ceiling_open_i};

  ////////////////////////////////////////////////////////////////////////
  // Debounce: high or floating reads as released
  logic btn_clean;

  wake_debounce u_debounce
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(tick),
    .raw_i(in_s.button_input),
    .clean_o(btn_clean)
  );

  function automatic logic elapsed(input logic [31:0] cnt,
                                   input logic [31:0] lim);
    elapsed = (cnt >= lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State machine
  wake_timer_pkg::state_t state_q, state_d;
  logic [31:0] st_cnt_q, st_cnt_d;
  logic [31:0] hold_cnt_q, hold_cnt_d;
  logic [31:0] req_cnt_q, req_cnt_d;
  logic sleep_prev_q, sleep_prev_d;
  logic btn_prev_q, btn_prev_d;
  logic started_q, started_d;
  logic press_fall, req_fall, run_mode, floor_ok, long_hold, long_req;
  logic sleep_quiet;

  assign press_fall = btn_prev_q && !btn_clean;
  assign req_fall = sleep_prev_q && !in_s.sleep_req;
  assign run_mode = (state_q == wake_timer_pkg::ST_AWAKE) ||
                    (state_q == wake_timer_pkg::ST_SLEEP) ||
                    (state_q == wake_timer_pkg::ST_FROM_OFF);
  assign floor_ok = elapsed(st_cnt_q, AWAKE_T);
  assign long_hold = elapsed(hold_cnt_q, HOLD_T);
  assign long_req = run_mode && elapsed(req_cnt_q, HOLD_T);
  // A request held through the sleep floor must wake first, not shut down
  assign sleep_quiet = (state_q == wake_timer_pkg::ST_SLEEP) &&
                       !elapsed(st_cnt_q, SLEEP_T);

  always_comb
  begin
    state_d = state_q;
    st_cnt_d = (tick && st_cnt_q != 32'hffffffff) ? st_cnt_q + 32'h1
                                                   : st_cnt_q;
    hold_cnt_d = btn_clean ? 32'h0 :
                 (tick && !long_hold) ? hold_cnt_q + 32'h1 : hold_cnt_q;
    // Sleep request length only counts in run mode
    req_cnt_d = (!in_s.sleep_req || !run_mode || sleep_quiet) ? 32'h0 :
                (tick && !long_req) ? req_cnt_q + 32'h1 : req_cnt_q;
    sleep_prev_d = in_s.sleep_req;
    btn_prev_d = btn_clean;
    started_d = 1'b1;
    if (!started_q)
      state_d = START_RUN ? wake_timer_pkg::ST_AWAKE
                          : wake_timer_pkg::ST_OFF;
    else if (run_mode && (long_hold || long_req))
      state_d = wake_timer_pkg::ST_SHUT_OFF;
    else
    begin
      unique case (state_q)
        wake_timer_pkg::ST_AWAKE,
        wake_timer_pkg::ST_FROM_OFF:
        begin
          if (floor_ok && (req_fall || in_s.ceiling_done ||
                           in_s.ceiling_open))
            state_d = wake_timer_pkg::ST_SLEEP;
        end
        wake_timer_pkg::ST_SLEEP:
        begin
          if (elapsed(st_cnt_q, SLEEP_T) &&
              (press_fall || in_s.period_done || in_s.sleep_req))
            state_d = wake_timer_pkg::ST_AWAKE;
        end
        wake_timer_pkg::ST_SHUT_OFF:
        begin
          if (elapsed(st_cnt_q, GRACE_T))
            state_d = wake_timer_pkg::ST_OFF;
        end
        wake_timer_pkg::ST_OFF:
        begin
          if (press_fall && !long_hold)
            state_d = wake_timer_pkg::ST_FROM_OFF;
        end
        default:
          state_d = wake_timer_pkg::ST_OFF;
      endcase
    end
    if (state_d != state_q)
      st_cnt_d = 32'h0;
    if (state_q == wake_timer_pkg::ST_OFF)
      st_cnt_d = 32'h0;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= wake_timer_pkg::ST_OFF;
      st_cnt_q <= 32'h0;
      hold_cnt_q <= 32'h0;
      req_cnt_q <= 32'h0;
      sleep_prev_q <= 1'b0;
      btn_prev_q <= 1'b1;
      started_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      st_cnt_q <= st_cnt_d;
      hold_cnt_q <= hold_cnt_d;
      req_cnt_q <= req_cnt_d;
      sleep_prev_q <= sleep_prev_d;
      btn_prev_q <= btn_prev_d;
      started_q <= started_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, registered so nothing glitches onto the regulator
  wake_timer_pkg::ctrl_out_t out_q, out_d;
  logic wake_flag_q, wake_flag_d;
  logic pwr;

  always_comb
  begin
    // Shutting Off keeps power so the system can finish
    pwr = (state_d == wake_timer_pkg::ST_AWAKE) ||
          (state_d == wake_timer_pkg::ST_FROM_OFF) ||
          (state_d == wake_timer_pkg::ST_SHUT_OFF);
    wake_flag_d = wake_flag_q;
    if (state_d == wake_timer_pkg::ST_FROM_OFF)
      wake_flag_d = 1'b1;
    else if (!pwr || state_d == wake_timer_pkg::ST_SHUT_OFF)
      wake_flag_d = 1'b0;
    out_d.power_en = INVERTED ? !pwr : pwr;
    out_d.button_clean_out = btn_clean;
    out_d.wake_from_off_flag = !wake_flag_d;
    out_d.going_down_flag =
      !(state_d == wake_timer_pkg::ST_SHUT_OFF);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= '{power_en: INVERTED, button_clean_out: 1'b1,
                 wake_from_off_flag: 1'b1, going_down_flag: 1'b1};
      wake_flag_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      wake_flag_q <= wake_flag_d;
    end
  end

  assign power_en_o = out_q.power_en;
  assign button_clean_out_o = 1'b0;
  assign button_clean_oe_n_o = out_q.button_clean_out;
  assign wake_from_off_flag_o = 1'b0;
  assign wake_from_off_oe_n_o = out_q.wake_from_off_flag;
  assign going_down_flag_o = 1'b0;
  assign going_down_oe_n_o = out_q.going_down_flag;
  assign state_o = state_q;

endmodule // wake_timer_power_control

// ---- wtpc_props.sv ----
// Checker: state, power and flag relations of the power control block.
// Assumes the bind below and a single clock domain.
`timescale 1ns/1ps
module wtpc_props
#(
  parameter int unsigned TICK_CYCLES = 4,
  parameter bit INVERTED = 1'b0
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic button_input_i,
  input wire logic power_en_o,
  input wire logic button_clean_oe_n_o,
  input wire logic wake_from_off_oe_n_o,
  input wire logic going_down_oe_n_o,
  input wire wake_timer_pkg::state_t state_o
);
  // Bounds allow a tick of slip, since the tick phase is free running
  localparam int TC = TICK_CYCLES;
  int dwell_q;
  logic on, run, slp, sho, off;
  // The block leaves Off by itself just after reset; skip that exit
  logic [1:0] boot_q;
  logic boot_done;
  assign boot_done = (boot_q == 2'h3);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      boot_q <= 2'h0;
    else if (boot_q != 2'h3)
      boot_q <= boot_q + 2'h1;
  end
  assign on = power_en_o != INVERTED;
  assign run = state_o inside {wake_timer_pkg::ST_AWAKE,
    wake_timer_pkg::ST_FROM_OFF};
  assign slp = state_o == wake_timer_pkg::ST_SLEEP;
  assign sho = state_o == wake_timer_pkg::ST_SHUT_OFF;
  assign off = state_o == wake_timer_pkg::ST_OFF;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dwell_q <= 0;
    else
      dwell_q <= $stable(state_o) ? dwell_q + 1 : 0;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_grace_end;
    sho ##1 off;
  endsequence
  sequence s_press_off;
    boot_done && off ##1 !off;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_sleep_unpowered: assert property (slp |-> !on)
    else $error("power on in sleep");
  chk_run_powered: assert property (run || sho |-> on)
    else $error("power off while running");
  chk_grace_flag: assert property (going_down_oe_n_o == !sho)
    else $error("going down flag wrong");
  chk_grace_bound: assert property (sho ##1 sho |-> dwell_q <= 1001*TC)
    else $error("grace too long");
  chk_grace_end: assert property (s_grace_end |->
    !on && going_down_oe_n_o && dwell_q >= 998*TC)
    else $error("bad end of grace");
  chk_wake_powered: assert property (!wake_from_off_oe_n_o |-> on)
    else $error("wake flag without power");
  chk_press_wakes: assert property (s_press_off |->
    state_o == wake_timer_pkg::ST_FROM_OFF && !wake_from_off_oe_n_o)
    else $error("bad wake from off");
  chk_off_holds: assert property (s_press_off |-> !button_clean_oe_n_o)
    else $error("left off without press");
  chk_awake_floor: assert property (run ##1 slp |-> dwell_q >= 7*TC-2)
    else $error("awake too short");
  chk_sleep_floor: assert property (slp ##1 !slp |-> dwell_q >= 127*TC-2)
    else $error("sleep too short");
  chk_clean_follow: assert property ($changed(button_clean_oe_n_o) |->
    button_clean_oe_n_o == $past(button_input_i, 100))
    else $error("clean button not debounced");
endmodule // wtpc_props

bind wake_timer_power_control wtpc_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .INVERTED(INVERTED)
) u_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .button_input_i(button_input_i),
  .power_en_o(power_en_o),
  .button_clean_oe_n_o(button_clean_oe_n_o),
  .wake_from_off_oe_n_o(wake_from_off_oe_n_o),
  .going_down_oe_n_o(going_down_oe_n_o),
  .state_o(state_o)
);

// ---- wake_system_model.sv ----
// Partner: supply switch and the controller it powers.
// Assumes a board pull-down on the request line while unpowered.
`timescale 1ns/1ps
module wake_system_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // From timer and bench
  input wire logic power_en_i,
  input wire logic force_hi_i,
  input wire logic [15:0] busy_i,
  // To timer
  output logic sleep_req_o
);
  logic [15:0] run_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_q <= 16'h0;
    else
      run_q <= power_en_i ? run_q + 16'h1 : 16'h0;
  end
  // Busy high after power-up; its falling edge ends the task
  assign sleep_req_o = force_hi_i | (power_en_i & (run_q < busy_i));
endmodule // wake_system_model

// ---- wake_timer_power_control_test.sv ----
// Testbench: scenario tasks for the power control block.
// Assumes a 4 cycle tick so the long counts stay short.
`timescale 1ns/1ps
module wake_timer_power_control_test;
  logic clk_i, rst_n_i, btn, rq, per, cdone, copen, fhi, pen, pen_inv;
  logic [2:0] od;
  logic cl_n, wk_n, dn_n;
  logic [15:0] busy;
  wake_timer_pkg::state_t st;
  int err_count;
  int checks_done;
  wake_timer_power_control #(.TICK_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .button_input_i(btn),
    .sleep_req_i(rq), .period_done_i(per), .ceiling_done_i(cdone),
    .ceiling_open_i(copen), .power_en_o(pen), .button_clean_out_o(od[0]),
    .button_clean_oe_n_o(cl_n), .wake_from_off_flag_o(od[1]),
    .wake_from_off_oe_n_o(wk_n), .going_down_flag_o(od[2]),
    .going_down_oe_n_o(dn_n), .state_o(st));
  // Inverted variant runs in lockstep on the same inputs
  wake_timer_power_control #(.INVERTED(1'b1), .TICK_CYCLES(4)) dut_inv (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .button_input_i(btn),
    .sleep_req_i(rq), .period_done_i(per), .ceiling_done_i(cdone),
    .ceiling_open_i(copen), .power_en_o(pen_inv), .button_clean_out_o(),
    .button_clean_oe_n_o(), .wake_from_off_flag_o(),
    .wake_from_off_oe_n_o(), .going_down_flag_o(),
    .going_down_oe_n_o(), .state_o());
  wake_system_model u_sys (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .power_en_i(pen), .force_hi_i(fhi), .busy_i(busy), .sleep_req_o(rq));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Bounded wait; running out ends the run at once
  task automatic wait_st(input wake_timer_pkg::state_t s, input int n);
    int i;
    i = 0;
    while (st !== s && i < n)
    begin
      @(negedge clk_i);
      i++;
    end
    chk(st === s, "state wait ran out");
    if (st !== s)
      summarize();
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_sleep();
    wait_st(wake_timer_pkg::ST_AWAKE, 10);
    chk(pen === 1'b1, "awake unpowered");
    chk(pen_inv === 1'b0, "inverted enable not low");
    wait_st(wake_timer_pkg::ST_SLEEP, 200);
    chk(pen === 1'b0, "sleep powered");
    chk(pen_inv === 1'b1, "inverted enable not high");
  endtask
  task automatic t_floor();
    @(posedge clk_i);
    per <= 1'b1;
    busy <= 16'h0008;
    repeat (400) @(negedge clk_i);
    chk(st === wake_timer_pkg::ST_SLEEP, "early wake");
    wait_st(wake_timer_pkg::ST_AWAKE, 200);
    @(posedge clk_i);
    per <= 1'b0;
    repeat (100) @(negedge clk_i);
    chk(st === wake_timer_pkg::ST_AWAKE, "early edge taken");
    @(posedge clk_i);
    cdone <= 1'b1;
    wait_st(wake_timer_pkg::ST_SLEEP, 20);
    @(posedge clk_i);
    cdone <= 1'b0;
  endtask
  task automatic t_shut();
    @(posedge clk_i);
    fhi <= 1'b1;
    repeat (300) @(negedge clk_i);
    chk(st === wake_timer_pkg::ST_SLEEP, "early wake");
    wait_st(wake_timer_pkg::ST_AWAKE, 300);
    wait_st(wake_timer_pkg::ST_SHUT_OFF, 700);
    chk(dn_n === 1'b0 && pen === 1'b1, "grace flags");
    @(posedge clk_i);
    fhi <= 1'b0;
    repeat (20) @(posedge clk_i);
    fhi <= 1'b1;
    wait_st(wake_timer_pkg::ST_OFF, 4100);
    chk(pen === 1'b0 && dn_n === 1'b1, "off flags");
    repeat (100) @(negedge clk_i);
    chk(st === wake_timer_pkg::ST_OFF, "request woke");
    @(posedge clk_i);
    fhi <= 1'b0;
  endtask
  task automatic t_press();
    @(posedge clk_i);
    busy <= 16'h0004;
    copen <= 1'b1;
    btn <= 1'b0;
    wait_st(wake_timer_pkg::ST_FROM_OFF, 200);
    chk(cl_n === 1'b0, "clean not pressed");
    chk(wk_n === 1'b0 && pen === 1'b1, "wake flag");
    chk(od === 3'h0, "open drain data not low");
    @(posedge clk_i);
    btn <= 1'b1;
    wait_st(wake_timer_pkg::ST_SLEEP, 60);
    chk(wk_n === 1'b1, "wake flag held");
    @(posedge clk_i);
    copen <= 1'b0;
    repeat (140) @(negedge clk_i);
    chk(cl_n === 1'b1, "clean not released");
  endtask
  task automatic t_long();
    repeat (400) @(posedge clk_i);
    btn <= 1'b0;
    wait_st(wake_timer_pkg::ST_AWAKE, 200);
    wait_st(wake_timer_pkg::ST_SHUT_OFF, 600);
    @(posedge clk_i);
    btn <= 1'b1;
    wait_st(wake_timer_pkg::ST_OFF, 4100);
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    btn = 1'b1;
    per = 1'b0;
    cdone = 1'b0;
    copen = 1'b0;
    fhi = 1'b0;
    busy = 16'h0064;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_sleep();
    t_floor();
    t_shut();
    t_press();
    t_long();
    summarize();
  end
endmodule // wake_timer_power_control_test
